// [fpic_core.sv]
// Purpose: power-down, boost mode, id readout and continuous read reset
// Assumes: spi mode 0 pins, sclk well below mclk/4, busy from array engine
// Notes:   pins pass two flops; edges seen on the synced copies
// Notes on behaviour
// - power-down runs only if chip select rises right after opcode bit eight
// - after that rise the low-power state is reached within entry time
// - in power-down only release opcode is decoded, all else ignored
// - device comes up in normal operation, not powered down
// - boost mode entered by opcode plus three dummy bytes
// - release, write enable or power-down leave boost mode
// - release only: opcode then rise, no commands during release wait
// - release with three dummy bytes shifts device id repeatedly, msb first
// - release opcode ignored while busy, running cycle untouched
// - opcode 90 address zero: manufacturer then device id
// - address one: device id first; both alternate until chip select rises
// - unique id opcode: four dummy bytes, then 64-bit number
// - jedec id: manufacturer, memory type, capacity bytes, msb first
// - continuous read bits Ax: next fast read starts at address
// - continuous read bits Ax: standard opcodes not decoded
// - quad: eight clocks of all ones clear continuous read mode
// - dual: sixteen clocks of all ones clear continuous read mode
// - busy high during erase or program, low when done
`timescale 1ns/10ps
module fpic_core #(
    parameter logic [7:0]  MFR_ID    = 8'h5a,  // arbitrary value
    parameter logic [7:0]  DEV_ID    = 8'h16,  // arbitrary value
    parameter logic [7:0]  MEM_TYPE  = 8'h40,  // arbitrary value
    parameter logic [7:0]  CAPACITY  = 8'h17,  // arbitrary value
    parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef, // arbitrary
    parameter int          TMR_W     = 8
) (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       nrst,
    // spi pins from the host
    input  wire logic       spi_cs_n,
    input  wire logic       spi_sclk,
    input  wire logic [3:0] spi_io,
    // serial data out, enable low while driving
    output logic            so,
    output logic            so_oe_n,
    // array engine side
    input  wire logic       busy,
    input  wire logic       crm_load,
    input  wire logic [7:0] crm_bits_in,
    input  wire logic       crm_quad,
    // state and forwarded commands
    output logic            power_down,
    output logic            charge_pump_boost_mode,
    output logic            crm_active,
    output logic            crm_read_start,
    output logic            cmd_valid,
    output logic [7:0]      cmd_code
);
    // =====================================================
    // elaboration checks
    if (fpic_pkg::PD_ENTRY_CYC >= 2 ** TMR_W || fpic_pkg::REL_CYC >= 2 ** TMR_W
        || fpic_pkg::REL_ID_CYC >= 2 ** TMR_W) begin : g_chk
        $error("timer width too small");
    end
    localparam logic [TMR_W-1:0] PD_T  = TMR_W'(fpic_pkg::PD_ENTRY_CYC);
    localparam logic [TMR_W-1:0] REL_T = TMR_W'(fpic_pkg::REL_CYC);
    localparam logic [TMR_W-1:0] RID_T = TMR_W'(fpic_pkg::REL_ID_CYC);
    localparam int PD_MAX = fpic_pkg::PD_ENTRY_CYC + 1;

    function automatic logic [6:0] arg_end(input logic [7:0] op);
        case (op)
            fpic_pkg::OP_REL, fpic_pkg::OP_MFR,
            fpic_pkg::OP_BOOST: arg_end = fpic_pkg::ARG3_END;
            fpic_pkg::OP_UID:   arg_end = fpic_pkg::ARG4_END;
            default:            arg_end = fpic_pkg::NO_END;
        endcase
    endfunction

    // =====================================================
    // pin synchronisers
    fpic_pkg::fpic_pins_t pin_s1_q, pin_s2_q, pin_s3_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_q <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
            pin_s2_q <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
            pin_s3_q <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
        end else begin
            pin_s1_q <= '{cs_n: spi_cs_n, sclk: spi_sclk, io: spi_io};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end
    logic sclk_rise, sclk_fall, cs_rise, cs_fall, lanes_one;
    assign sclk_rise = pin_s2_q.sclk & ~pin_s3_q.sclk;
    assign sclk_fall = ~pin_s2_q.sclk & pin_s3_q.sclk;
    assign cs_rise   = pin_s2_q.cs_n & ~pin_s3_q.cs_n;
    assign cs_fall   = ~pin_s2_q.cs_n & pin_s3_q.cs_n;
    assign lanes_one = crm_quad ? &pin_s2_q.io : &pin_s2_q.io[1:0];

    // =====================================================
    // command state
    fpic_pkg::fpic_state_t st_q, st_d;
    fpic_pkg::fpic_tact_t  tact_q, tact_d;
    logic [6:0]       cnt_q, cnt_d;
    logic [7:0]       sh_q, sh_d, op_q, op_d, crm_q, crm_d, code_q, code_d;
    logic [63:0]      out_q, out_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic so_q, so_d, oe_n_q, oe_n_d, pd_q, pd_d, boost_q, boost_d;
    logic cv_q, cv_d, crs_q, crs_d, crm_on, ones_q, ones_d, crm_act_q, crm_act_d;
    logic [7:0] code;
    logic [6:0] cnt_inc;
    assign crm_on  = crm_q[7:4] == fpic_pkg::CRM_ON;
    assign code    = {sh_q[6:0], pin_s2_q.io[0]};
    assign cnt_inc = (cnt_q == fpic_pkg::NO_END) ? cnt_q : cnt_q + 7'h01;
    always_comb begin
        st_d = st_q; tact_d = tact_q; cnt_d = cnt_q; sh_d = sh_q;
        op_d = op_q; crm_d = crm_q; code_d = code_q; out_d = out_q;
        tmr_d = tmr_q; so_d = so_q; oe_n_d = oe_n_q; pd_d = pd_q;
        boost_d = boost_q; ones_d = ones_q;
        cv_d = 1'b0;
        crs_d = 1'b0;
        // entry and release timer
        if (tmr_q != '0) begin
            tmr_d = tmr_q - 1'b1;
            if (tmr_q == TMR_W'(1)) begin
                if (tact_q == fpic_pkg::TA_ENTER) pd_d = 1'b1;
                if (tact_q == fpic_pkg::TA_LEAVE) pd_d = 1'b0;
                tact_d = fpic_pkg::TA_NONE;
            end
        end
        case (st_q)
            fpic_pkg::ST_IDLE: begin
                if (cs_fall) begin
                    cnt_d = '0;
                    ones_d = 1'b1;
                    if (tmr_q != '0) st_d = fpic_pkg::ST_SKIP;
                    else if (crm_on) st_d = fpic_pkg::ST_CRM;
                    else st_d = fpic_pkg::ST_OPC;
                end
            end
            fpic_pkg::ST_OPC: begin
                if (sclk_rise) begin
                    sh_d = code;
                    cnt_d = cnt_inc;
                    if (cnt_q == fpic_pkg::OPC_BITS - 7'h01) begin
                        op_d = code;
                        st_d = fpic_pkg::ST_ARG;
                        if (pd_q) begin
                            // only release decoded, and never while busy
                            if (code != fpic_pkg::OP_REL || busy)
                                st_d = fpic_pkg::ST_SKIP;
                        end else if (code == fpic_pkg::OP_REL && busy) begin
                            st_d = fpic_pkg::ST_SKIP;
                        end else begin
                            if (code == fpic_pkg::OP_REL || code == fpic_pkg::OP_WREN
                                || code == fpic_pkg::OP_PD)
                                boost_d = 1'b0;
                            case (code)
                                fpic_pkg::OP_REL, fpic_pkg::OP_MFR, fpic_pkg::OP_UID,
                                fpic_pkg::OP_BOOST, fpic_pkg::OP_PD: ;
                                fpic_pkg::OP_JEDEC: begin
                                    out_d = {MFR_ID, MEM_TYPE, CAPACITY, 40'h0};
                                    st_d = fpic_pkg::ST_OUT;
                                end
                                default: begin
                                    cv_d = 1'b1;
                                    code_d = code;
                                    st_d = fpic_pkg::ST_SKIP;
                                end
                            endcase
                        end
                    end
                end
            end
            fpic_pkg::ST_ARG: begin
                if (sclk_rise) begin
                    sh_d = code;
                    cnt_d = cnt_inc;
                    if (cnt_inc == arg_end(op_q)) begin
                        st_d = fpic_pkg::ST_OUT;
                        case (op_q)
                            fpic_pkg::OP_REL: out_d = {8{DEV_ID}};
                            fpic_pkg::OP_UID: out_d = UNIQUE_ID;
                            fpic_pkg::OP_MFR: begin
                                // last address bit picks which id leads
                                if (pin_s2_q.io[0]) out_d = {4{DEV_ID, MFR_ID}};
                                else out_d = {4{MFR_ID, DEV_ID}};
                            end
                            default: st_d = fpic_pkg::ST_DONE;
                        endcase
                    end
                end
            end
            fpic_pkg::ST_OUT: begin
                // 64 is a multiple of 8 and 16, so rotation repeats the ids
                if (sclk_fall) begin
                    so_d = out_q[63];
                    out_d = {out_q[62:0], out_q[63]};
                    oe_n_d = 1'b0;
                end
            end
            fpic_pkg::ST_CRM: begin
                if (sclk_rise) begin
                    cnt_d = cnt_inc;
                    ones_d = ones_q & lanes_one;
                    // any zero or a long frame means an opcode-less read
                    if (!lanes_one || cnt_inc > (crm_quad ? fpic_pkg::CRM_QUAD_N
                                                          : fpic_pkg::CRM_DUAL_N)) begin
                        crs_d = 1'b1;
                        st_d = fpic_pkg::ST_SKIP;
                    end
                end
            end
            fpic_pkg::ST_DONE, fpic_pkg::ST_SKIP: ;
            default: st_d = fpic_pkg::ST_IDLE;
        endcase
        // select rising ends every frame and commits pending actions
        if (cs_rise) begin
            st_d = fpic_pkg::ST_IDLE;
            oe_n_d = 1'b1;
            if (st_q == fpic_pkg::ST_ARG && op_q == fpic_pkg::OP_PD && !pd_q
                && cnt_q == fpic_pkg::OPC_BITS) begin
                tmr_d = PD_T;
                tact_d = fpic_pkg::TA_ENTER;
            end
            if (st_q == fpic_pkg::ST_DONE && op_q == fpic_pkg::OP_BOOST)
                boost_d = 1'b1;
            if (pd_q && op_q == fpic_pkg::OP_REL
                && (st_q == fpic_pkg::ST_ARG || st_q == fpic_pkg::ST_OUT)) begin
                tact_d = fpic_pkg::TA_LEAVE;
                tmr_d = (st_q == fpic_pkg::ST_ARG && cnt_q == fpic_pkg::OPC_BITS)
                        ? REL_T : RID_T;
            end
            if (st_q == fpic_pkg::ST_CRM && ones_q && cnt_q == (crm_quad
                ? fpic_pkg::CRM_QUAD_N : fpic_pkg::CRM_DUAL_N))
                crm_d = fpic_pkg::CRM_CLEAR;
        end
        // engine load wins over a clear in the same cycle
        if (crm_load) crm_d = crm_bits_in;
        crm_act_d = crm_d[7:4] == fpic_pkg::CRM_ON;
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_q    <= fpic_pkg::ST_IDLE;
            tact_q  <= fpic_pkg::TA_NONE;
            cnt_q   <= '0;
            sh_q    <= '0;
            op_q    <= '0;
            crm_q   <= fpic_pkg::CRM_RST;
            code_q  <= '0;
            out_q   <= '0;
            tmr_q   <= '0;
            so_q    <= 1'b0;
            oe_n_q  <= 1'b1;
            pd_q    <= fpic_pkg::PD_RST;
            boost_q <= fpic_pkg::BOOST_RST;
            ones_q  <= 1'b1;
            cv_q    <= 1'b0;
            crs_q   <= 1'b0;
            crm_act_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            tact_q  <= tact_d;
            cnt_q   <= cnt_d;
            sh_q    <= sh_d;
            op_q    <= op_d;
            crm_q   <= crm_d;
            code_q  <= code_d;
            out_q   <= out_d;
            tmr_q   <= tmr_d;
            so_q    <= so_d;
            oe_n_q  <= oe_n_d;
            pd_q    <= pd_d;
            boost_q <= boost_d;
            ones_q  <= ones_d;
            cv_q    <= cv_d;
            crs_q   <= crs_d;
            crm_act_q <= crm_act_d;
        end
    end

    assign so                     = so_q;
    assign so_oe_n                = oe_n_q;
    assign power_down             = pd_q;
    assign charge_pump_boost_mode = boost_q;
    assign crm_active             = crm_act_q;
    assign crm_read_start         = crs_q;
    assign cmd_valid              = cv_q;
    assign cmd_code               = code_q;

    // =====================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    property p_pd_exact;
        (cs_rise && st_q == fpic_pkg::ST_ARG && op_q == fpic_pkg::OP_PD
         && cnt_q != fpic_pkg::OPC_BITS && tmr_q == '0) |=> tmr_q == '0;
    endproperty
    a_pd_exact: assert property (p_pd_exact) else $error("late power-down ran");
    property p_pd_entry;
        (cs_rise && st_q == fpic_pkg::ST_ARG && op_q == fpic_pkg::OP_PD && !pd_q
         && cnt_q == fpic_pkg::OPC_BITS) |-> ##[1:PD_MAX] pd_q;
    endproperty
    a_pd_entry: assert property (p_pd_entry) else $error("power-down not reached");
    property p_pd_quiet;
        pd_q |=> !cv_q && !boost_q;
    endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("command seen in power-down");
    property p_boost_cause;
        $rose(boost_q) |-> $past(op_q) == fpic_pkg::OP_BOOST && $past(cs_rise);
    endproperty
    a_boost_cause: assert property (p_boost_cause) else $error("boost without opcode");
    property p_boost_exit;
        (st_q == fpic_pkg::ST_OPC && sclk_rise && cnt_q == 7'h07 && !pd_q && !busy
         && (code == fpic_pkg::OP_WREN || code == fpic_pkg::OP_PD)) |=> !boost_q;
    endproperty
    a_boost_exit: assert property (p_boost_exit) else $error("boost not left");
    property p_busy_rel;
        (st_q == fpic_pkg::ST_OPC && sclk_rise && cnt_q == 7'h07 && busy
         && code == fpic_pkg::OP_REL) |=> st_q == fpic_pkg::ST_SKIP && $stable(pd_q);
    endproperty
    a_busy_rel: assert property (p_busy_rel) else $error("release taken while busy");
    property p_cs_end;
        cs_rise |=> oe_n_q ##1 (oe_n_q && st_q == fpic_pkg::ST_IDLE);
    endproperty
    a_cs_end: assert property (p_cs_end) else $error("output kept after select");
    property p_crm_block;
        (crm_on && st_q == fpic_pkg::ST_IDLE && cs_fall && tmr_q == '0)
        |=> st_q == fpic_pkg::ST_CRM ##1 !cv_q;
    endproperty
    a_crm_block: assert property (p_crm_block) else $error("opcode decoded in crm");
    property p_crm_clear;
        (cs_rise && st_q == fpic_pkg::ST_CRM && ones_q && crm_quad && !crm_load
         && cnt_q == fpic_pkg::CRM_QUAD_N) |=> !crm_active;
    endproperty
    a_crm_clear: assert property (p_crm_clear) else $error("crm not cleared");
endmodule // fpic_core

// [fpic_pkg.sv]
// Purpose: constants and types of the power and id command block
// Assumes: core clock mclk at 25 MHz
// Notes:   times in ns, cycle counts derived from them
package fpic_pkg;
    // =====================================================
    // opcodes
    localparam logic [7:0] OP_PD    = 8'hb9;
    localparam logic [7:0] OP_BOOST = 8'ha3;
    localparam logic [7:0] OP_REL   = 8'hab;
    localparam logic [7:0] OP_WREN  = 8'h06;
    localparam logic [7:0] OP_MFR   = 8'h90;
    localparam logic [7:0] OP_UID   = 8'h4b;
    localparam logic [7:0] OP_JEDEC = 8'h9f;
    // =====================================================
    // bit counts within a frame
    localparam logic [6:0] OPC_BITS   = 7'h08;
    localparam logic [6:0] ARG3_END   = 7'h20;
    localparam logic [6:0] ARG4_END   = 7'h28;
    localparam logic [6:0] NO_END     = 7'h7f;
    localparam logic [6:0] CRM_QUAD_N = 7'h08;
    localparam logic [6:0] CRM_DUAL_N = 7'h10;
    // =====================================================
    // reset, clear and mode values
    localparam logic [7:0] CRM_RST   = 8'h00;
    localparam logic [7:0] CRM_CLEAR = 8'hff;
    localparam logic [3:0] CRM_ON    = 4'ha;
    localparam logic       PD_RST    = 1'b0;
    localparam logic       BOOST_RST = 1'b0;
    // =====================================================
    // timing
    localparam int CLK_NS = 40;
    localparam int POWER_DOWN_ENTRY_TIME_NS = 3000;
    localparam int RELEASE_WAIT_TIME_NS     = 3000;
    localparam int RELEASE_ID_WAIT_TIME_NS  = 1800;
    // longest times round down, never below one cycle
    function automatic int cyc_floor(input int ns);
        return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
    endfunction
    localparam int PD_ENTRY_CYC = cyc_floor(POWER_DOWN_ENTRY_TIME_NS);
    localparam int REL_CYC      = cyc_floor(RELEASE_WAIT_TIME_NS);
    localparam int REL_ID_CYC   = cyc_floor(RELEASE_ID_WAIT_TIME_NS);
    // =====================================================
    // types
    typedef struct packed {
        logic       cs_n;
        logic       sclk;
        logic [3:0] io;
    } fpic_pins_t;
    typedef enum logic [1:0] {TA_NONE, TA_ENTER, TA_LEAVE} fpic_tact_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_OPC, ST_ARG, ST_DONE, ST_OUT, ST_SKIP, ST_CRM
    } fpic_state_t;
endpackage

// [fpic_host_model.sv]
// Purpose: spi host model that drives chip select, clock and lanes
// Assumes: mode 0, clock stands low outside frames
// Notes:   io[1] is released unless quad; the bench resolves that wire
`timescale 1ns/10ps
module fpic_host_model #(
    parameter int HALF = 8
) (
    // clock
    input  wire logic            mclk,
    // pins towards the flash
    output fpic_pkg::fpic_pins_t pins,
    output logic                 lane1_drv,
    // resolved data line from the flash
    input  wire logic            miso
);
    // =====================================================
    // idle
    initial begin
        pins      = '{cs_n: 1'b1, sclk: 1'b0, io: 4'he};
        lane1_drv = 1'b0;
    end
    // =====================================================
    // one frame: ntx bits out msb first, then nrx bits in
    task automatic frame(input logic [63:0] tx, input int ntx, input int nrx,
                         input logic quad, output logic [63:0] rx);
        logic b;
        rx = '0;
        @(posedge mclk);
        pins.cs_n <= 1'b0;
        lane1_drv <= quad;
        for (int i = 0; i < ntx + nrx; i++) begin
            b = (i < 64) ? tx[63 - i] : 1'b0;
            pins.io <= quad ? {4{b}} : {3'b111, b};
            repeat (HALF) @(posedge mclk);
            pins.sclk <= 1'b1;
            if (i >= ntx) rx = {rx[62:0], miso};
            repeat (HALF) @(posedge mclk);
            pins.sclk <= 1'b0;
        end
        repeat (HALF) @(posedge mclk);
        // select rises right after the last counted bit
        pins.cs_n <= 1'b1;
        pins.io   <= ~pins.io;
        lane1_drv <= 1'b0;
        repeat (HALF) @(posedge mclk);
    endtask
endmodule // fpic_host_model

// [tb_fpic_core.sv]
// Purpose: self-checking bench for the power and id command block
// Assumes: host model paces sclk at 16 mclk per bit
// Notes:   id values below are arbitrary
`timescale 1ns/10ps
module tb_fpic_core;
    localparam logic [7:0]  MFR = 8'h3c;
    localparam logic [7:0]  DEV = 8'h21;
    localparam logic [7:0]  TYP = 8'h52;
    localparam logic [7:0]  CAP = 8'h19;
    localparam logic [63:0] UID = 64'hfeed_0bad_1357_2468;
    logic        mclk, nrst, busy, crm_load, crm_quad, lane1_drv;
    logic        so, so_oe_n, power_down, boost, crm_active, crm_read_start, cmd_valid;
    logic [7:0]  crm_bits_in, cmd_code, op;
    logic [3:0]  spi_io;
    logic [63:0] rx;
    logic        a0;
    fpic_pkg::fpic_pins_t pins;
    int num_errors = 0;
    int n_checks = 0;
    int crm_starts = 0;
    int cmd_seen = 0;
    int seed, st;
    // released data line is pulled high
    assign spi_io = {pins.io[3:2], lane1_drv ? pins.io[1] : (so_oe_n ? 1'b1 : so), pins.io[0]};
    fpic_core #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(TYP), .CAPACITY(CAP), .UNIQUE_ID(UID))
    u_fpic_core (.mclk(mclk), .nrst(nrst), .spi_cs_n(pins.cs_n), .spi_sclk(pins.sclk),
        .spi_io(spi_io), .so(so), .so_oe_n(so_oe_n), .busy(busy), .crm_load(crm_load),
        .crm_bits_in(crm_bits_in), .crm_quad(crm_quad), .power_down(power_down),
        .charge_pump_boost_mode(boost), .crm_active(crm_active),
        .crm_read_start(crm_read_start), .cmd_valid(cmd_valid), .cmd_code(cmd_code));
    fpic_host_model u_fpic_host_model (.mclk(mclk), .pins(pins), .lane1_drv(lane1_drv),
        .miso(spi_io[1]));
    always @(posedge mclk) if (crm_read_start === 1'b1) crm_starts <= crm_starts + 1;
    always @(posedge mclk) if (cmd_valid === 1'b1) cmd_seen <= cmd_seen + 1;
    // =====================================================
    // helpers
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic send(input logic [63:0] tx, input int ntx, input int nrx);
        u_fpic_host_model.frame(tx, ntx, nrx, 1'b0, rx);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    function automatic logic [63:0] id_pair(input logic a);
        return a ? {4{DEV, MFR}} : {4{MFR, DEV}};
    endfunction
    // =====================================================
    // clock and watchdog
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        cyc(80000);
        num_errors++;
        results();
    end
    // =====================================================
    // tests
    initial begin
        nrst = 1'b0; busy = 1'b0; crm_load = 1'b0; crm_quad = 1'b0; crm_bits_in = 8'h00;
        seed = 32'h5fc5;
        cyc(10);
        nrst <= 1'b1;
        cyc(5);
        u_fpic_host_model.frame({64{1'b1}}, 16, 0, 1'b1, rx);
        check("power_down", power_down, 64'h0);
        check("boost", boost, 64'h0);
        send({fpic_pkg::OP_JEDEC, 56'h0}, 8, 24);
        check("jedec", rx[23:0], {MFR, TYP, CAP});
        check("so_oe_n", so_oe_n, 64'h1);
        for (int a = 0; a < 2; a++) begin
            send({fpic_pkg::OP_MFR, 23'h0, a[0], 32'h0}, 32, 64);
            check("mfr_dev", rx, id_pair(a[0]));
        end
        send({fpic_pkg::OP_REL, 56'h0}, 32, 16);
        check("dev_id", rx[15:0], {DEV, DEV});
        send({fpic_pkg::OP_UID, 56'h0}, 40, 64);
        check("unique_id", rx, UID);
        $display("test ids done");
        for (int k = 0; k < 2; k++) begin
            send({fpic_pkg::OP_BOOST, 56'h0}, 32, 0);
            check("boost_on", boost, 64'h1);
            send({k ? fpic_pkg::OP_REL : fpic_pkg::OP_WREN, 56'h0}, 8, 0);
            check("boost_off", boost, 64'h0);
            cyc(100);
        end
        for (int n = 7; n < 10; n += 2) begin
            send({fpic_pkg::OP_PD, 56'h0}, n, 0);
            cyc(100);
            check("pd_bad_len", power_down, 64'h0);
        end
        send({fpic_pkg::OP_BOOST, 56'h0}, 32, 0);
        send({fpic_pkg::OP_PD, 56'h0}, 8, 0);
        check("boost_pd", boost, 64'h0);
        cyc(60);
        check("pd_early", power_down, 64'h0);
        cyc(20);
        check("pd_entered", power_down, 64'h1);
        send({fpic_pkg::OP_JEDEC, 56'h0}, 8, 24);
        check("pd_ignored", rx[23:0], 24'hffffff);
        st = cmd_seen;
        send({8'h0b, 56'h0}, 8, 0);
        check("pd_no_cmd", 64'(cmd_seen - st), 64'h0);
        busy <= 1'b1;
        send({fpic_pkg::OP_REL, 56'h0}, 8, 0);
        busy <= 1'b0;
        cyc(100);
        check("rel_busy", power_down, 64'h1);
        send({fpic_pkg::OP_REL, 56'h0}, 8, 0);
        send({fpic_pkg::OP_JEDEC, 56'h0}, 8, 24);
        check("rel_wait", rx[23:0], 24'hffffff);
        cyc(90);
        check("released", power_down, 64'h0);
        send({fpic_pkg::OP_PD, 56'h0}, 8, 0);
        cyc(100);
        send({fpic_pkg::OP_REL, 56'h0}, 32, 16);
        check("rel_id", rx[15:0], {DEV, DEV});
        cyc(60);
        check("rel_id_pd", power_down, 64'h0);
        $display("test power done");
        for (int r = 0; r < 8; r++) begin
            op = 8'($random(seed));
            if (op inside {8'hb9, 8'ha3, 8'hab, 8'h06, 8'h90, 8'h4b, 8'h9f, 8'hff}) op = 8'h0b;
            st = cmd_seen;
            send({op, 56'h0}, 8, 0);
            check("cmd_code", cmd_code, op);
            check("cmd_valid", 64'(cmd_seen - st), 64'h1);
            a0 = 1'($random(seed));
            send({fpic_pkg::OP_MFR, 23'h0, a0, 32'h0}, 32, 64);
            check("mfr_rand", rx, id_pair(a0));
        end
        $display("test random done");
        for (int q = 0; q < 2; q++) begin
            send({fpic_pkg::OP_BOOST, 56'h0}, 32, 0);
            @(posedge mclk);
            crm_bits_in <= 8'ha5;
            crm_load    <= 1'b1;
            crm_quad    <= q[0];
            @(posedge mclk);
            crm_load <= 1'b0;
            cyc(2);
            check("crm_on", crm_active, 64'h1);
            st = crm_starts;
            send({fpic_pkg::OP_JEDEC, 56'h0}, 8, 24);
            check("crm_no_decode", rx[23:0], 24'hffffff);
            check("crm_start", 64'(crm_starts != st), 64'h1);
            u_fpic_host_model.frame({64{1'b1}}, q ? 8 : 16, 0, 1'b1, rx);
            check("crm_clear", crm_active, 64'h0);
            send({fpic_pkg::OP_JEDEC, 56'h0}, 8, 24);
            check("crm_decode", rx[23:0], {MFR, TYP, CAP});
        end
        $display("test crm done");
        results();
    end
endmodule // tb_fpic_core
